//--- core/tcp_pkg.sv
// constants, register map and field layout of the timer/counter block
// assumes one 40 MHz clock and an Avalon-MM register master
//
// How it works
// - clock source select clear: count once per instruction cycle without prescaler
// - a write to the count register holds off counting for two instruction cycles
// - clock source select set: count external edges, edge select picks rising or falling
// - prescaler assign clear gives prescaler to timer, set gives it to watchdog
// - timer-side prescale ratio spans 1:2 to 1:256 in powers of two
// - prescaler count is never visible or writable from software
// - wrap of the count register from FFh to 00h sets the overflow flag
// - overflow interrupt forwarded only while the overflow interrupt enable is set
// - counting stops during sleep, so overflow cannot wake the core
// - prescaler output, or raw external input, sampled in phase two and phase four
// - count increments three to seven oscillator periods after an external edge
// - exactly one 8-bit prescaler, shared exclusively by timer or watchdog
// - writing the count register with prescaler on timer zeroes the prescaler
// - watchdog clear instruction zeroes prescaler and watchdog when assigned there
package tcp_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] TCP_ADDR_COUNT   = 4'h0;
    localparam logic [3:0] TCP_ADDR_OPTION  = 4'h4;
    localparam logic [3:0] TCP_ADDR_IRQCTL  = 4'h8;
    localparam logic [3:0] TCP_ADDR_STATUS  = 4'hC;
    localparam int         TCP_ADDR_W       = 4;
    // option register fields
    localparam int TCP_OPT_CS    = 5;
    localparam int TCP_OPT_SE    = 4;
    localparam int TCP_OPT_PSA   = 3;
    localparam int TCP_OPT_PS_LO = 0;
    localparam int TCP_PS_W      = 3;
    localparam logic [7:0] TCP_OPTION_RST = 8'hFF;
    // interrupt control fields
    localparam int TCP_IRQ_EN    = 5;
    localparam int TCP_IRQ_FLAG  = 2;
    // status fields
    localparam int TCP_ST_ASLEEP = 0;
    localparam int TCP_ST_WDOG   = 1;
    // phase clock: four oscillator periods make one instruction cycle
    localparam int TCP_PHASES      = 4;
    localparam logic [1:0] TCP_PH_TWO  = 2'h1;
    localparam logic [1:0] TCP_PH_FOUR = 2'h3;
    // write inhibit length in instruction cycles
    localparam logic [1:0] TCP_WR_INHIBIT = 2'h2;
    localparam logic [7:0] TCP_ZERO8 = 8'h00;
    localparam logic [7:0] TCP_FULL8 = 8'hFF;

    // prescaler bit that makes the divided output for a given ratio field
    function automatic logic [2:0] tcp_tap(input logic [TCP_PS_W-1:0] ps);
        return ps;
    endfunction
endpackage

//--- core/tcp_prescaler.sv
// the single 8-bit prescaler shared between timer and watchdog
// assumes the caller supplies one-cycle advance and clear pulses
`timescale 1ns/100ps
module tcp_prescaler
    import tcp_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input  wire logic                mclk_in,
    input  wire logic                reset_in,
    // control
    input  wire logic                advance_in,
    input  wire logic                clear_in,
    input  wire logic [TCP_PS_W-1:0] ratio_in,
    // divided output as a level
    output logic                     tap_out,
    output logic [WIDTH-1:0]         count_out
);
    logic [WIDTH-1:0] count_reg;

    // clear beats advance so a write always starts from zero
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            count_reg <= '0;
        else if (clear_in)
            count_reg <= '0;
        else if (advance_in)
            count_reg <= count_reg + 1'b1;
    end

    // bit n toggles at input/2^(n+1), so its edges mark the ratio
    assign tap_out   = count_reg[tcp_tap(ratio_in)];
    assign count_out = count_reg;
endmodule

//--- core/tcp_timer.sv
// top of the timer/counter with shared prescaler, Avalon-MM slave
// assumes synchronous pin inputs and a 40 MHz oscillator clock
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
module tcp_timer
    import tcp_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // core side
    input  wire logic        external_count_input_in,
    input  wire logic        sleep_in,
    input  wire logic        watchdog_clear_instr_in,
    input  wire logic        watchdog_tick_in,
    output logic             watchdog_clear_out,
    output logic             watchdog_timeout_out,
    output logic             irq_out
);
    logic [7:0]  count_register_reg;
    logic [7:0]  option_reg;
    logic        overflow_flag_reg;
    logic        overflow_irq_enable_reg;
    logic [1:0]  phase_reg;
    logic [1:0]  inhibit_reg;
    logic        waitreq_reg;
    logic [31:0] rdata_reg;
    logic        sample_ph2_reg;
    logic        sample_ph4_reg;
    logic        tap_prev_reg;
    logic        wd_clear_reg;
    logic        wd_to_reg;
    logic        irq_reg;
    logic        ext_prev_reg;

    logic        clock_source_select;
    logic        source_edge_select;
    logic        prescaler_assign;
    logic [2:0]  prescale_ratio;
    logic        wr_access;
    logic        rd_access;
    logic        wr_count;
    logic        cycle_end;
    logic        ext_edge;
    logic        raw_event;
    logic        psc_advance;
    logic        psc_clear;
    logic        psc_tap;
    logic        tap_rise;
    logic        sync_rise;
    logic        timer_inc;
    logic        wrap;
    logic [7:0]  psc_count;

    assign clock_source_select = option_reg[TCP_OPT_CS];
    assign source_edge_select  = option_reg[TCP_OPT_SE];
    assign prescaler_assign    = option_reg[TCP_OPT_PSA];
    assign prescale_ratio      = option_reg[TCP_OPT_PS_LO +: TCP_PS_W];

    // a write lands only at the edge where the master sees waitrequest low;
    // read data is captured one edge earlier so it stands at that edge
    assign wr_access = avs_write_in && !waitreq_reg;
    assign rd_access = avs_read_in && waitreq_reg;
    assign wr_count  = wr_access && avs_address_in == TCP_ADDR_COUNT && avs_byteenable_in[0];

    // bus handshake: waitrequest drops for exactly one cycle per request,
    // kept as its own flip-flop so the output carries no logic
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            waitreq_reg <= 1'b1;
        else
            waitreq_reg <= !((avs_read_in || avs_write_in) && waitreq_reg);
    end

    assign avs_waitrequest_out = waitreq_reg;

    // read mux; prescaler count is deliberately not mapped
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            rdata_reg <= '0;
        else if (rd_access)
        begin
            case (avs_address_in)
                TCP_ADDR_COUNT:  rdata_reg <= {24'h000000, count_register_reg};
                TCP_ADDR_OPTION: rdata_reg <= {24'h000000, option_reg};
                TCP_ADDR_IRQCTL: rdata_reg <= {24'h000000, 2'h0, overflow_irq_enable_reg,
                                               2'h0, overflow_flag_reg, 2'h0};
                TCP_ADDR_STATUS: rdata_reg <= {30'h00000000, prescaler_assign, sleep_in};
                default:         rdata_reg <= 32'h00000000;
            endcase
        end
    end

    assign avs_readdata_out = rdata_reg;

    // option register
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            option_reg <= TCP_OPTION_RST;
        else if (wr_access && avs_address_in == TCP_ADDR_OPTION && avs_byteenable_in[0])
            option_reg <= avs_writedata_in[7:0];
    end

    // phase counter: four oscillator phases per instruction cycle
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            phase_reg <= 2'h0;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    assign cycle_end = phase_reg == TCP_PH_FOUR;

    // edge detect on external pin, polarity chosen by edge select
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            ext_prev_reg <= 1'b0;
        else
            ext_prev_reg <= external_count_input_in;
    end

    assign ext_edge = source_edge_select ? (ext_prev_reg && !external_count_input_in)
                                         : (!ext_prev_reg && external_count_input_in);

    // event into the prescaler: instruction cycle or external edge; none in sleep
    assign raw_event   = clock_source_select ? ext_edge : cycle_end;
    assign psc_advance = raw_event && !prescaler_assign && !sleep_in;
    assign psc_clear   = (wr_count && !prescaler_assign)
                      || (watchdog_clear_instr_in && prescaler_assign);

    tcp_prescaler #(
        .WIDTH (8)
    ) u_prescaler (
        .mclk_in    (mclk_in),
        .reset_in   (reset_in),
        .advance_in (psc_advance || (prescaler_assign && watchdog_tick_in)),
        .clear_in   (psc_clear),
        .ratio_in   (prescale_ratio),
        .tap_out    (psc_tap),
        .count_out  (psc_count)
    );

    // a falling tap bit marks one divided period
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            tap_prev_reg <= 1'b0;
        else
            tap_prev_reg <= psc_tap;
    end

    assign tap_rise = tap_prev_reg && !psc_tap && !psc_clear;

    // synchroniser: source level sampled in phase two and again in phase four
    // without prescaler in counter mode the raw pin is what gets sampled
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sample_ph2_reg <= 1'b0;
            sample_ph4_reg <= 1'b0;
        end
        else
        begin
            if (phase_reg == TCP_PH_TWO)
                sample_ph2_reg <= prescaler_assign ? (external_count_input_in ^ source_edge_select)
                                                   : psc_tap;
            if (cycle_end)
            begin
                sample_ph4_reg <= sample_ph2_reg;
            end
        end
    end

    // increment on the phase-four edge that first takes the new level, 3..6 phases
    // after a raw pin edge, 4..7 through the prescaler; waiting one more instruction cycle would overshoot 7
    assign sync_rise = cycle_end && sample_ph2_reg && !sample_ph4_reg;

    // timer mode without prescaler counts each instruction cycle directly
    always_comb
    begin
        timer_inc = 1'b0;
        if (!sleep_in)
        begin
            if (clock_source_select)
                timer_inc = prescaler_assign ? sync_rise : (sync_rise && 1'b1);
            else
                timer_inc = prescaler_assign ? cycle_end : tap_rise;
        end
    end

    // write inhibit counts down two instruction cycles after a count write
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            inhibit_reg <= 2'h0;
        else if (wr_count)
            inhibit_reg <= TCP_WR_INHIBIT;
        else if (cycle_end && inhibit_reg != 2'h0)
            inhibit_reg <= inhibit_reg - 2'h1;
    end

    // a count write in the same cycle wins, so no wrap is reported then
    assign wrap = timer_inc && !wr_count && inhibit_reg == 2'h0 && count_register_reg == TCP_FULL8;

    // count register: write wins, otherwise increment
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            count_register_reg <= TCP_ZERO8;
        else if (wr_count)
            count_register_reg <= avs_writedata_in[7:0];
        else if (timer_inc && inhibit_reg == 2'h0)
            count_register_reg <= count_register_reg + 8'h01;
    end

    // overflow flag: set beats a software clear in the same cycle
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            overflow_flag_reg       <= 1'b0;
            overflow_irq_enable_reg <= 1'b0;
        end
        else
        begin
            if (wrap)
                overflow_flag_reg <= 1'b1;
            else if (wr_access && avs_address_in == TCP_ADDR_IRQCTL && avs_byteenable_in[0])
                overflow_flag_reg <= avs_writedata_in[TCP_IRQ_FLAG];
            if (wr_access && avs_address_in == TCP_ADDR_IRQCTL && avs_byteenable_in[0])
                overflow_irq_enable_reg <= avs_writedata_in[TCP_IRQ_EN];
        end
    end

    // interrupt level, registered so the output comes from a flip-flop
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            irq_reg <= 1'b0;
        else
            irq_reg <= overflow_flag_reg && overflow_irq_enable_reg;
    end

    assign irq_out = irq_reg;

    // watchdog side: clear pulse and postscaled timeout when prescaler is theirs
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wd_clear_reg <= 1'b0;
            wd_to_reg    <= 1'b0;
        end
        else
        begin
            wd_clear_reg <= watchdog_clear_instr_in;
            wd_to_reg    <= prescaler_assign ? (watchdog_tick_in && psc_count == TCP_FULL8)
                                             : watchdog_tick_in;
        end
    end

    assign watchdog_clear_out   = wd_clear_reg;
    assign watchdog_timeout_out = wd_to_reg;
endmodule

//--- verification/tcp_pulse_source.sv
// external count source driving the count pin in bursts of toggles
// assumes the bench pulses go_in for one cycle while busy_out is low
`timescale 1ns/100ps
module tcp_pulse_source
(
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       go_in,
    input  wire logic [3:0] toggles_in,
    output logic            pin_out,
    output logic            busy_out
);
    logic [3:0] left_reg;
    logic [1:0] hold_reg;
    // four clocks per level: double the minimum width, and the period also suits the prescaled path
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            left_reg <= 4'h0;
            hold_reg <= 2'h0;
            pin_out  <= 1'b0;
        end
        else if (go_in && left_reg == 4'h0)
        begin
            left_reg <= toggles_in;
            hold_reg <= 2'h3;
        end
        else if (left_reg != 4'h0)
        begin
            hold_reg <= hold_reg - 2'h1;
            if (hold_reg == 2'h0)
            begin
                pin_out  <= !pin_out;
                left_reg <= left_reg - 4'h1;
            end
        end
    end
    assign busy_out = (left_reg != 4'h0);
endmodule

//--- verification/tcp_timer_properties.sv
// bus, watchdog clear and interrupt checks for the timer block
// assumes one clock domain; bound onto every tcp_timer
`timescale 1ns/100ps
module tcp_timer_properties
    import tcp_pkg::*;
(
    // clock and reset
    input wire logic        mclk_in,
    input wire logic        reset_in,
    // register bus
    input wire logic [3:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    // core side
    input wire logic        watchdog_clear_instr_in,
    input wire logic        watchdog_clear_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // read accepted at this edge
    logic rd_ack;
    assign rd_ack = avs_read_in && !avs_waitrequest_out;

    chk_ack_next: assert property ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
        else $error("bus answer not one cycle after request");
    chk_ack_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    chk_ack_cause: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
        else $error("answer without request");
    chk_unmapped_zero: assert property (rd_ack && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (rd_ack |-> avs_readdata_out[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_wdog_clear: assert property (watchdog_clear_instr_in |=> watchdog_clear_out)
        else $error("watchdog clear not forwarded");
    chk_wdog_cause: assert property (watchdog_clear_out |-> $past(watchdog_clear_instr_in))
        else $error("watchdog clear without instruction");
    // only software may take the flag away, so a fall needs a recent write
    chk_irq_sticky: assert property ($fell(irq_out) |-> $past(avs_write_in) || $past(avs_write_in, 2))
        else $error("interrupt dropped without a write");
endmodule

bind tcp_timer tcp_timer_properties u_props (.mclk_in(mclk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .watchdog_clear_instr_in(watchdog_clear_instr_in), .watchdog_clear_out(watchdog_clear_out),
    .irq_out(irq_out));

//--- verification/test_tcp_timer.sv
// self-checking bench: registers, timer rate, prescaler, interrupt, counter pin, sleep
// assumes tcp_pkg, the bound checker and the pulse source model
`timescale 1ns/100ps
module test_tcp_timer
    import tcp_pkg::*;
;
    logic        mclk_in = 1'b0, reset_in = 1'b1, rd = 1'b0, wr = 1'b0, go = 1'b0;
    logic        sleep = 1'b0, wci = 1'b0, tick = 1'b0;
    logic [3:0]  adr = 4'h0, be = 4'hF, tg = 4'h0;
    logic [31:0] wd = 32'h0, rdata, q, v;
    logic        waitreq, irq, pin, busy, wclr, wto;
    int          failures = 0, checks = 0;
    always #12.5 mclk_in = !mclk_in;

    tcp_timer dut (.mclk_in(mclk_in), .reset_in(reset_in), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .external_count_input_in(pin), .sleep_in(sleep),
        .watchdog_clear_instr_in(wci), .watchdog_tick_in(tick), .watchdog_clear_out(wclr),
        .watchdog_timeout_out(wto), .irq_out(irq));
    tcp_pulse_source src (.mclk_in(mclk_in), .reset_in(reset_in), .go_in(go), .toggles_in(tg),
        .pin_out(pin), .busy_out(busy));

    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // range compare; an unknown never satisfies it
    task automatic cmp(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
        checks++;
        if ((g >= lo && g <= hi) !== 1'b1)
        begin
            failures++;
            $display("Error at %0t: got %h, expected %h to %h", $time, g, lo, hi);
        end
    endtask
    // one bus cycle, held until waitrequest is sampled low
    task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d, input logic [3:0] b);
        @(posedge mclk_in);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        be <= b;
        for (int n = 0; n < 40; n++)
        begin
            @(posedge mclk_in);
            if (waitreq === 1'b0)
                break;
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (waitreq !== 1'b0)
        begin
            failures++;
            complete_run();
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d, 4'hF);
    endtask
    task automatic rreg(input logic [3:0] a);
        xfer(a, 1'b0, 8'h00, 4'hF);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    task automatic t_regs;
        rreg(TCP_ADDR_OPTION);
        cmp(q, 32'hFF, 32'hFF);
        rreg(TCP_ADDR_IRQCTL);
        cmp(q, 32'h00, 32'h00);
        rreg(4'h2);
        cmp(q, 32'h00, 32'h00);
        xfer(TCP_ADDR_OPTION, 1'b1, 8'h00, 4'hE);
        wreg(TCP_ADDR_STATUS, 8'hFF);
        rreg(TCP_ADDR_OPTION);
        cmp(q, 32'hFF, 32'hFF);
        rreg(TCP_ADDR_STATUS);
        cmp(q, 32'h02, 32'h02);
        $display("regs done");
    endtask
    task automatic t_timer;
        wreg(TCP_ADDR_OPTION, 8'h08);
        wreg(TCP_ADDR_COUNT, 8'h10);
        idle(40);
        rreg(TCP_ADDR_COUNT);
        cmp(q, 32'h17, 32'h19);
        v = q;
        idle(78);
        rreg(TCP_ADDR_COUNT);
        cmp(8'(q - v), 32'h14, 32'h14);
        $display("timer done");
    endtask
    task automatic t_scale;
        for (int p = 0; p < 4; p++)
        begin
            wreg(TCP_ADDR_OPTION, 8'(p));
            rreg(TCP_ADDR_COUNT);
            v = q;
            idle(398);
            rreg(TCP_ADDR_COUNT);
            cmp(8'(q - v), 400 / (8 << p) - 1, 400 / (8 << p) + 1);
        end
        // ratio 1:256, write lands with the prescaler part way through
        wreg(TCP_ADDR_OPTION, 8'h07);
        idle(600);
        wreg(TCP_ADDR_COUNT, 8'h40);
        idle(900);
        rreg(TCP_ADDR_COUNT);
        cmp(q, 32'h40, 32'h40);
        idle(300);
        rreg(TCP_ADDR_COUNT);
        cmp(q, 32'h41, 32'h41);
        $display("prescaler done");
    endtask
    task automatic t_irq;
        @(posedge mclk_in);
        wci <= 1'b1;
        tick <= 1'b1;
        @(posedge mclk_in);
        wci <= 1'b0;
        tick <= 1'b0;
        @(posedge mclk_in);
        cmp(wclr, 32'h1, 32'h1);
        cmp(wto, 32'h1, 32'h1);
        wreg(TCP_ADDR_COUNT, 8'h00);
        wreg(TCP_ADDR_OPTION, 8'h08);
        wreg(TCP_ADDR_IRQCTL, 8'h20);
        wreg(TCP_ADDR_COUNT, 8'hFE);
        rreg(TCP_ADDR_IRQCTL);
        cmp(q, 32'h20, 32'h20);
        idle(30);
        rreg(TCP_ADDR_IRQCTL);
        cmp(q, 32'h24, 32'h24);
        cmp(irq, 32'h1, 32'h1);
        wreg(TCP_ADDR_IRQCTL, 8'h04);
        idle(2);
        cmp(irq, 32'h0, 32'h0);
        idle(200);
        rreg(TCP_ADDR_IRQCTL);
        cmp(q, 32'h04, 32'h04);
        wreg(TCP_ADDR_IRQCTL, 8'h24);
        idle(2);
        cmp(irq, 32'h1, 32'h1);
        wreg(TCP_ADDR_IRQCTL, 8'h20);
        idle(2);
        cmp(irq, 32'h0, 32'h0);
        $display("interrupt done");
    endtask
    // three toggles: the chosen edge occurs twice, the other once
    task automatic burst(input logic [7:0] opt);
        wreg(TCP_ADDR_OPTION, opt);
        idle(10);
        rreg(TCP_ADDR_COUNT);
        v = q;
        @(posedge mclk_in);
        go <= 1'b1;
        tg <= 4'h3;
        @(posedge mclk_in);
        go <= 1'b0;
        @(posedge mclk_in);
        for (int n = 0; n < 100 && busy !== 1'b0; n++)
            @(posedge mclk_in);
        cmp(busy, 32'h0, 32'h0);
        if (busy !== 1'b0)
            complete_run();
        idle(5);
        rreg(TCP_ADDR_COUNT);
        cmp(8'(q - v), 32'h2, 32'h2);
        $display("counter burst done");
    endtask
    task automatic t_sleep;
        @(posedge mclk_in);
        sleep <= 1'b1;
        idle(4);
        rreg(TCP_ADDR_COUNT);
        v = q;
        idle(100);
        rreg(TCP_ADDR_COUNT);
        cmp(q, v, v);
        rreg(TCP_ADDR_STATUS);
        cmp(q, 32'h03, 32'h03);
        @(posedge mclk_in);
        sleep <= 1'b0;
        $display("sleep done");
    endtask

    initial
    begin
        repeat (3) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_regs();
        t_timer();
        t_scale();
        t_irq();
        burst(8'h28);
        burst(8'h38);
        wreg(TCP_ADDR_OPTION, 8'h08);
        t_sleep();
        complete_run();
    end
endmodule
